// File: logic/cjb_pkg.sv
// constants, instruction codes and tap state type for the configuration jtag block
package cjb_pkg;
    // instruction register geometry
    localparam int CJB_IR_WIDTH = 10;
    localparam logic [CJB_IR_WIDTH-1:0] CJB_IR_CAPTURE = 10'h001;
    localparam logic [CJB_IR_WIDTH-1:0] CJB_IR_RESET = 10'h3FF;

    // instruction codes, values arbitrary
    localparam logic [CJB_IR_WIDTH-1:0] CJB_OP_BYPASS = 10'h3FF;
    localparam logic [CJB_IR_WIDTH-1:0] CJB_OP_SELECT_USER_CLOCK = 10'h00B;
    localparam logic [CJB_IR_WIDTH-1:0] CJB_OP_REVERT_TO_INTERNAL_OSCILLATOR = 10'h00C;
    localparam logic [CJB_IR_WIDTH-1:0] CJB_OP_SET_FLASH_BOOT_ADDRESS = 10'h027;

    // boot address registers
    localparam int CJB_BOOT_WIDTH = 22;
    localparam int CJB_BOOT_LSB_ZEROS = 2;
    localparam int CJB_FLASH_ADDR_WIDTH = CJB_BOOT_WIDTH + CJB_BOOT_LSB_ZEROS;
    localparam logic [CJB_BOOT_WIDTH-1:0] CJB_BOOT_RESET = 22'h000000;

    // user clock cycles needed to finish the switch back
    localparam int CJB_REVERT_CYCLES = 10;
    localparam int CJB_REVERT_CNT_WIDTH = 4;
    localparam logic [CJB_REVERT_CNT_WIDTH-1:0] CJB_REVERT_LOAD = 4'hA;

    // pin synchroniser depth
    localparam int CJB_SYNC_STAGES = 2;

    // tap states, gray codes along the usual walk
    typedef enum logic [3:0] {
        CJB_TLR  = 4'h0,
        CJB_RTI  = 4'h1,
        CJB_SDR  = 4'h3,
        CJB_CDR  = 4'h2,
        CJB_SHDR = 4'h6,
        CJB_E1DR = 4'h7,
        CJB_PDR  = 4'h5,
        CJB_E2DR = 4'h4,
        CJB_UDR  = 4'hC,
        CJB_SIR  = 4'hD,
        CJB_CIR  = 4'hF,
        CJB_SHIR = 4'hE,
        CJB_E1IR = 4'hA,
        CJB_PIR  = 4'hB,
        CJB_E2IR = 4'h9,
        CJB_UIR  = 4'h8
    } cjb_tap_state_t;
endpackage

// File: logic/cjb_sync.sv
// multi-bit two flip-flop synchroniser for pins from outside the clk domain
`timescale 1ns/10ps
module cjb_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage [STAGES];

    // refused at elaboration, a single stage would pass metastable values on
    if (STAGES < 2 || WIDTH < 1) begin : g_badParams
        $error("cjb_sync needs at least two stages and one bit");
    end

    // only the next stage reads each flop, metastability stays contained
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < STAGES; i++) stage[i] <= '0;
        end else if (ce) begin
            stage[0] <= asyncIn;
            for (int i = 1; i < STAGES; i++) stage[i] <= stage[i-1];
        end
    end

    assign syncOut = stage[STAGES-1];
endmodule

// File: logic/cjb_tap_config.sv
// tap with clock source select and flash boot address instructions
`timescale 1ns/10ps

// How it works
// - select-user-clock instruction switches configuration clock to the user clock pin, only while the oscillator is enabled.
// - user clock stays selected while other instructions load and run.
// - only revert instruction or power-on reset return clock to oscillator.
// - revert instruction clears the user clock enable latch.
// - boot address instruction puts a 22-bit shift register between tdi and tdo.
// - shifted bits go to a 22-bit update register feeding the flash controller.
// - capture copies update register into shift register for readout.
// - stored value is address over four; two zero bits appended below.
// - with remote update on, boot address only applies to factory image.
// - boot address survives reconfiguration, lost at power cycle only.
// - boot address only steers the active parallel scheme.
module cjb_tap_config import cjb_pkg::*; #(
    parameter logic [CJB_FLASH_ADDR_WIDTH-1:0] DEFAULT_FLASH_ADDR = 24'h000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoEnable,
    input wire logic userClockPin,
    input wire logic oscillatorEnabled,
    input wire logic reconfigure,
    input wire logic activeParallelScheme,
    input wire logic remoteUpdateEnabled,
    input wire logic loadingFactoryImage,
    output logic configClockFromUser,
    output logic userClockLatch,
    output logic bootAddressOverride,
    output logic [CJB_FLASH_ADDR_WIDTH-1:0] flashBootAddress
);
    // refused at elaboration, the revert count must fit its counter
    if (CJB_REVERT_CYCLES >= (1 << CJB_REVERT_CNT_WIDTH)) begin : g_badCount
        $error("revert counter too narrow");
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronised pins and edge detection

    logic [3:0] pinSync;
    logic tckPrev;
    logic userClockPrev;

    cjb_sync #(
        .WIDTH(4),
        .STAGES(CJB_SYNC_STAGES)
    ) pinSyncInst (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .asyncIn({userClockPin, tdi, tms, tck}),
        .syncOut(pinSync)
    );

    wire tckS = pinSync[0];
    wire tmsS = pinSync[1];
    wire tdiS = pinSync[2];
    wire userClockS = pinSync[3];
    wire tckRise = tckS && !tckPrev;
    wire tckFall = !tckS && tckPrev;
    wire userClockRise = userClockS && !userClockPrev;

    // previous samples, read only after the synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tckPrev <= 1'b0;
            userClockPrev <= 1'b0;
        end else if (ce) begin
            tckPrev <= tckS;
            userClockPrev <= userClockS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tap controller

    function automatic cjb_tap_state_t tapNext(input cjb_tap_state_t s, input logic m);
        case (s)
            CJB_TLR: tapNext = m ? CJB_TLR : CJB_RTI;
            CJB_RTI: tapNext = m ? CJB_SDR : CJB_RTI;
            CJB_SDR: tapNext = m ? CJB_SIR : CJB_CDR;
            CJB_CDR: tapNext = m ? CJB_E1DR : CJB_SHDR;
            CJB_SHDR: tapNext = m ? CJB_E1DR : CJB_SHDR;
            CJB_E1DR: tapNext = m ? CJB_UDR : CJB_PDR;
            CJB_PDR: tapNext = m ? CJB_E2DR : CJB_PDR;
            CJB_E2DR: tapNext = m ? CJB_UDR : CJB_SHDR;
            CJB_UDR: tapNext = m ? CJB_SDR : CJB_RTI;
            CJB_SIR: tapNext = m ? CJB_TLR : CJB_CIR;
            CJB_CIR: tapNext = m ? CJB_E1IR : CJB_SHIR;
            CJB_SHIR: tapNext = m ? CJB_E1IR : CJB_SHIR;
            CJB_E1IR: tapNext = m ? CJB_UIR : CJB_PIR;
            CJB_PIR: tapNext = m ? CJB_E2IR : CJB_PIR;
            CJB_E2IR: tapNext = m ? CJB_UIR : CJB_SHIR;
            CJB_UIR: tapNext = m ? CJB_SDR : CJB_RTI;
            default: tapNext = CJB_TLR;
        endcase
    endfunction

    cjb_tap_state_t tapState;
    cjb_tap_state_t next_tapState;

    // reconfiguration restarts only the tap, never the latched settings
    assign next_tapState = tapNext(tapState, tmsS);

    always_ff @(posedge clk) begin
        if (!rst_n || (ce && reconfigure)) begin
            tapState <= CJB_TLR;
        end else if (ce && tckRise) begin
            tapState <= next_tapState;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction register

    logic [CJB_IR_WIDTH-1:0] irShift;
    logic [CJB_IR_WIDTH-1:0] instruction;

    wire tapInReset = (tapState == CJB_TLR);
    wire irCapture = tckRise && (tapState == CJB_CIR);
    wire irShiftEn = tckRise && (tapState == CJB_SHIR);
    wire irUpdate = tckRise && (tapState == CJB_UIR);
    wire [CJB_IR_WIDTH-1:0] next_irShift = {tdiS, irShift[CJB_IR_WIDTH-1:1]};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irShift <= CJB_IR_CAPTURE;
            instruction <= CJB_IR_RESET;
        end else if (ce) begin
            if (irCapture) irShift <= CJB_IR_CAPTURE;
            else if (irShiftEn) irShift <= next_irShift;
            if (tapInReset || reconfigure) instruction <= CJB_IR_RESET;
            else if (irUpdate) instruction <= irShift;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data registers: bypass and boot address

    logic bypassBit;
    logic [CJB_BOOT_WIDTH-1:0] bootShift;
    logic [CJB_BOOT_WIDTH-1:0] bootUpdate;
    logic bootProgrammed;

    wire selBoot = (instruction == CJB_OP_SET_FLASH_BOOT_ADDRESS);
    wire drCapture = tckRise && (tapState == CJB_CDR);
    wire drShiftEn = tckRise && (tapState == CJB_SHDR);
    wire drUpdate = tckRise && (tapState == CJB_UDR);
    wire [CJB_BOOT_WIDTH-1:0] next_bootShift = {tdiS, bootShift[CJB_BOOT_WIDTH-1:1]};

    // boot address chain, power-on reset alone clears it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bootShift <= CJB_BOOT_RESET;
            bootUpdate <= CJB_BOOT_RESET;
            bootProgrammed <= 1'b0;
            bypassBit <= 1'b0;
        end else if (ce) begin
            if (drCapture && selBoot) bootShift <= bootUpdate;
            else if (drShiftEn && selBoot) bootShift <= next_bootShift;
            if (drUpdate && selBoot) begin
                bootUpdate <= bootShift;
                bootProgrammed <= 1'b1;
            end
            if (drCapture) bypassBit <= 1'b0;
            else if (drShiftEn) bypassBit <= tdiS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tdo driven on the falling tck edge so the host samples a settled bit

    wire inShiftIr = (tapState == CJB_SHIR);
    wire inShiftDr = (tapState == CJB_SHDR);
    wire drOut = selBoot ? bootShift[0] : bypassBit;
    wire next_tdo = inShiftIr ? irShift[0] : drOut;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tdo <= 1'b0;
            tdoEnable <= 1'b0;
        end else if (ce && tckFall) begin
            tdo <= next_tdo;
            tdoEnable <= inShiftIr || inShiftDr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration clock source

    logic [CJB_REVERT_CNT_WIDTH-1:0] revertCount;

    wire selectIssued = irUpdate && (irShift == CJB_OP_SELECT_USER_CLOCK);
    wire revertIssued = irUpdate && (irShift == CJB_OP_REVERT_TO_INTERNAL_OSCILLATOR);
    wire revertPending = (revertCount != '0);

    // latch ignores tap reset and all other instructions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            userClockLatch <= 1'b0;
        end else if (ce) begin
            if (revertIssued) userClockLatch <= 1'b0;
            else if (selectIssued && oscillatorEnabled) userClockLatch <= 1'b1;
        end
    end

    // switch back only completes after ten user clock edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            revertCount <= '0;
            configClockFromUser <= 1'b0;
        end else if (ce) begin
            if (selectIssued && oscillatorEnabled) begin
                revertCount <= '0; // fresh select cancels a pending switch back
            end else if (revertIssued && configClockFromUser) begin
                revertCount <= CJB_REVERT_LOAD;
            end else if (revertPending && userClockRise) begin
                revertCount <= revertCount - 1'b1;
            end
            if (selectIssued && oscillatorEnabled) configClockFromUser <= 1'b1;
            else if (revertPending && userClockRise && revertCount == 4'h1) configClockFromUser <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flash start address for the active parallel controller

    function automatic logic [CJB_FLASH_ADDR_WIDTH-1:0] toFlashAddr(input logic [CJB_BOOT_WIDTH-1:0] w);
        toFlashAddr = {w, {CJB_BOOT_LSB_ZEROS{1'b0}}};
    endfunction

    wire imageTakesAddr = !remoteUpdateEnabled || loadingFactoryImage;
    wire next_override = bootProgrammed && activeParallelScheme && imageTakesAddr;
    wire [CJB_FLASH_ADDR_WIDTH-1:0] next_flashAddr = next_override ? toFlashAddr(bootUpdate) : DEFAULT_FLASH_ADDR;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bootAddressOverride <= 1'b0;
            flashBootAddress <= '0;
        end else if (ce) begin
            bootAddressOverride <= next_override;
            flashBootAddress <= next_flashAddr;
        end
    end
endmodule

// File: testbench/cjb_tap_config_assertions.sv
// port assertions for the configuration tap block
`timescale 1ns/10ps
module cjb_tap_config_assertions import cjb_pkg::*; #(
    parameter logic [CJB_FLASH_ADDR_WIDTH-1:0] DEFAULT_FLASH_ADDR = 24'h000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdoEnable,
    input wire logic oscillatorEnabled,
    input wire logic activeParallelScheme,
    input wire logic remoteUpdateEnabled,
    input wire logic loadingFactoryImage,
    input wire logic configClockFromUser,
    input wire logic userClockLatch,
    input wire logic bootAddressOverride,
    input wire logic [CJB_FLASH_ADDR_WIDTH-1:0] flashBootAddress
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////
    // clock source latch and select
    a_latch_user: assert property (userClockLatch |-> configClockFromUser)
        else $error("latch without user clock");
    a_osc_needed: assert property ($rose(userClockLatch) |-> $past(oscillatorEnabled))
        else $error("select without oscillator");
    a_user_kept: assert property (userClockLatch |=> configClockFromUser)
        else $error("user clock dropped");
    a_revert_only: assert property ($fell(configClockFromUser) |-> !$past(userClockLatch, 2))
        else $error("clock reverted while latched");
    ////////////////////////////////
    // boot address gating and format
    a_ap_only: assert property ((!activeParallelScheme) [*2] |-> !bootAddressOverride)
        else $error("override outside parallel scheme");
    a_factory_only: assert property ((remoteUpdateEnabled && !loadingFactoryImage) [*2]
        |-> !bootAddressOverride) else $error("override for other image");
    a_default_addr: assert property (!bootAddressOverride |-> flashBootAddress == DEFAULT_FLASH_ADDR)
        else $error("default address not shown");
    a_low_zeros: assert property (bootAddressOverride |-> flashBootAddress[1:0] == 2'b00)
        else $error("address low bits set");
    // tdo may only move while tck has been low
    a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck) && !$past(tck, 2))
        else $error("tdo moved outside tck low");
    a_tdoen_on_fall: assert property ($changed(tdoEnable) |-> !$past(tck) && !$past(tck, 2))
        else $error("tdo enable moved outside tck low");
endmodule
bind cjb_tap_config cjb_tap_config_assertions #(.DEFAULT_FLASH_ADDR(DEFAULT_FLASH_ADDR)) uChk (
    .clk(clk), .rst_n(rst_n), .tck(tck), .tdo(tdo), .tdoEnable(tdoEnable), .oscillatorEnabled(oscillatorEnabled),
    .activeParallelScheme(activeParallelScheme), .remoteUpdateEnabled(remoteUpdateEnabled),
    .loadingFactoryImage(loadingFactoryImage), .configClockFromUser(configClockFromUser),
    .userClockLatch(userClockLatch), .bootAddressOverride(bootAddressOverride), .flashBootAddress(flashBootAddress)
);

// File: testbench/cjb_jtag_host.sv
// jtag host model driving the tap pins and the user clock pin
`timescale 1ns/10ps
module cjb_jtag_host import cjb_pkg::*; (
    input wire logic clk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic userClockPin
);
    int half = 8; // clk cycles per half period, raise for a slow host
    // clocks stand still low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        userClockPin = 1'b0;
    end
    // n tck periods, tms and tdi lsb first; tdo taken just before each rise
    task automatic seq(input logic [31:0] m, input logic [31:0] d, input int n, output logic [31:0] o);
        o = '0;
        @(posedge clk);
        // tms and tdi move with the tck fall, period is exactly two halves
        for (int i = 0; i < n; i++) begin
            tms <= m[i];
            tdi <= d[i];
            repeat (half) @(posedge clk);
            o[i] = tdo;
            tck <= 1'b1;
            repeat (half) @(posedge clk);
            tck <= 1'b0;
        end
    endtask
    task automatic resetTap();
        logic [31:0] o;
        seq(32'h0000001F, 32'h0, 6, o); // five tms high, then idle
    endtask
    // idle, instruction path, idle
    task automatic loadIr(input logic [CJB_IR_WIDTH-1:0] code);
        logic [31:0] o;
        seq(32'h00006003, {18'h0, code, 4'h0}, 16, o);
    endtask
    // idle, data path, idle; value already divided by four
    task automatic shiftDr(input logic [21:0] v, output logic [21:0] q);
        logic [31:0] o;
        seq(32'h03000001, {7'h0, v, 3'h0}, 27, o);
        q = o[24:3];
    endtask
    task automatic uclk(input int n);
        repeat (n) begin
            @(posedge clk);
            userClockPin <= 1'b1;
            repeat (half) @(posedge clk);
            userClockPin <= 1'b0;
            repeat (half) @(posedge clk);
        end
    endtask
endmodule

// File: testbench/tb_top.sv
// self-checking bench for the configuration tap block
`timescale 1ns/10ps
module tb_top import cjb_pkg::*; ();
    logic clk, rst_n, ce, oscEn, reconf, apScheme, remoteUpd, factoryImg;
    logic tck, tms, tdi, tdo, tdoEn, userClk, cfgUser, latch, override;
    int enCycles = 0;
    logic [CJB_FLASH_ADDR_WIDTH-1:0] flashAddr;
    int n_fail = 0;
    int n_tests = 0;
    cjb_tap_config DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoEnable(tdoEn), .userClockPin(userClk), .oscillatorEnabled(oscEn), .reconfigure(reconf),
        .activeParallelScheme(apScheme), .remoteUpdateEnabled(remoteUpd), .loadingFactoryImage(factoryImg),
        .configClockFromUser(cfgUser), .userClockLatch(latch), .bootAddressOverride(override),
        .flashBootAddress(flashAddr));
    cjb_jtag_host host (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .userClockPin(userClk));
    // cycles with tdo driven, free running so only differences matter
    always @(posedge clk) begin
        if (tdoEn === 1'b1) enCycles <= enCycles + 1;
    end
    ////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // let registered outputs land before looking
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic gate(input logic a, input logic r, input logic f);
        @(posedge clk);
        apScheme <= a;
        remoteUpd <= r;
        factoryImg <= f;
        hold(3);
    endtask
    // reconfiguration sends the tap home, so the host walks it back to idle
    task automatic reconfig();
        @(posedge clk);
        reconf <= 1'b1;
        @(posedge clk);
        reconf <= 1'b0;
        hold(2);
        host.resetTap();
    endtask
    task automatic t_por();
        host.resetTap();
        chk(cfgUser, 1'b0, "clock at reset");
        chk(latch, 1'b0, "latch at reset");
        chk(flashAddr, 24'h000000, "address at reset");
        chk(override, 1'b0, "override at reset");
        chk(tdoEn, 1'b0, "tdo enable idle");
    endtask
    ////////////////////////////////
    task automatic t_boot();
        logic [21:0] rd;
        int enBase;
        host.loadIr(CJB_OP_SET_FLASH_BOOT_ADDRESS);
        enBase = enCycles;
        host.shiftDr(22'h2AF379, rd);
        chk(24'(enCycles - enBase), 24'(CJB_BOOT_WIDTH * 2 * host.half), "tdo enable span");
        chk(rd, 22'h000000, "first capture");
        chk(flashAddr, 24'hABCDE4, "boot address");
        host.shiftDr(22'h3FFFFF, rd);
        chk(rd, 22'h2AF379, "read back");
        reconfig();
        chk(flashAddr, 24'hFFFFFC, "after reconfigure");
        gate(1'b1, 1'b1, 1'b0);
        chk(override, 1'b0, "other image");
        gate(1'b1, 1'b1, 1'b1);
        chk(flashAddr, 24'hFFFFFC, "factory image");
        gate(1'b0, 1'b0, 1'b0);
        chk(flashAddr, 24'h000000, "other scheme");
        gate(1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_clock();
        logic [21:0] rd;
        @(posedge clk);
        oscEn <= 1'b0;
        host.loadIr(CJB_OP_SELECT_USER_CLOCK);
        chk(latch, 1'b0, "select, oscillator off");
        @(posedge clk);
        oscEn <= 1'b1;
        host.loadIr(CJB_OP_SELECT_USER_CLOCK);
        chk(cfgUser, 1'b1, "user clock chosen");
        host.loadIr(CJB_OP_SET_FLASH_BOOT_ADDRESS);
        host.shiftDr(22'h000001, rd);
        host.loadIr(CJB_OP_BYPASS);
        reconfig();
        chk(cfgUser, 1'b1, "user clock kept");
        host.loadIr(CJB_OP_REVERT_TO_INTERNAL_OSCILLATOR);
        chk(latch, 1'b0, "latch cleared");
        host.uclk(9);
        chk(cfgUser, 1'b1, "switched back early");
        // a user clock edge while the block is frozen must not count
        @(posedge clk);
        ce <= 1'b0;
        host.uclk(1);
        @(posedge clk);
        ce <= 1'b1;
        hold(2);
        chk(cfgUser, 1'b1, "edge counted while frozen");
        host.uclk(1);
        hold(2);
        chk(cfgUser, 1'b0, "oscillator again");
        host.loadIr(CJB_OP_SELECT_USER_CLOCK);
        @(posedge clk);
        rst_n <= 1'b0;
        hold(6);
        @(posedge clk);
        rst_n <= 1'b1;
        hold(3);
        t_por();
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // reset for 6 cycles, then the scenarios
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        oscEn = 1'b1;
        reconf = 1'b0;
        apScheme = 1'b1;
        remoteUpd = 1'b0;
        factoryImg = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        hold(3);
        t_por();
        t_boot();
        t_clock();
        tally_and_finish();
    end
    // scenarios take about 37 us; beyond 600 us something hangs
    initial begin
        #600000;
        n_fail++;
        tally_and_finish();
    end
endmodule
